/* File: rtl/tap_pkg.sv */
// Package with register map, field layout, windows and state encodings
//Contract
//- Slope per axis is current sample minus previous sample, halved.
//- Single tap: slope exceeds threshold, returns below before shock window ends.
//- Without latching the tap interrupt stays high exactly the quiet window.
//- With latching the tap interrupt stays high until the report is read.
//- Mode bit 0 gives single taps only; 1 gives single and double.
//- Second tap starts only after quiet window, before latency window expires.
//- Second tap must fall below threshold within shock; then double-tap fires.
//- Any over-threshold slope in the quiet window cancels double-tap recognition.
//- Latency window starts right after the first tap's quiet window.
//- Only axes with their enable bit set take part in recognition.
//- Five-bit threshold compared with slope magnitude of either sign.
//- Shock field 0 gives 4 samples, else N times 8 samples.
//- Quiet field 0 gives 2 samples, else N times 4 samples.
//- Latency field 0 gives 16 samples, else N times 32 samples.
//- Single and double tap reach pin one only through own routing bits.
//- Inactivity state suppresses all tap interrupts.
//- Report: b7 zero, b6 any, b5 single, b4 double, b3 sign, b2..b0 axes.
//- Sign bit is 0 for positive, 1 for negative tap acceleration.
//- Latching applies to single taps in mode 0, double taps in mode 1.
//- Latching without pin routing has no effect; interrupt acts non-latched.
//- Inactivity means slow forced rate; the rate setting stays unchanged.
package tap_pkg;
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h22;
   localparam logic [7:0] ADDR_ROUTING = 8'h23;
   localparam logic [7:0] ADDR_KNOCK_THS = 8'h30;
   localparam logic [7:0] ADDR_TIMING = 8'h33;
   localparam logic [7:0] ADDR_ACT_CFG = 8'h34;
   localparam logic [7:0] ADDR_REPORT = 8'h38;
   // control_three fields
   localparam int LATCH_BIT = 2;
   localparam int AXIS_EN_LSB = 3;
   // pin1_routing_control fields
   localparam int TWO_ROUTE_BIT = 3;
   localparam int ONE_ROUTE_BIT = 6;
   // activity_threshold_config mode bit
   localparam int DOUBLE_MODE_BIT = 7;
   // tap_window_timing fields
   localparam int SHOCK_LSB = 0;
   localparam int QUIET_LSB = 2;
   localparam int GAP_LSB = 4;
   localparam logic [7:0] RESET_VAL = 8'h00;
   // Window scaling
   localparam int SHOCK_ZERO = 4;
   localparam int SHOCK_STEP = 8;
   localparam int QUIET_ZERO = 2;
   localparam int QUIET_STEP = 4;
   localparam int GAP_ZERO = 16;
   localparam int GAP_STEP = 32;
   localparam int CNT_W = 10;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SHOCK1 = 3'b001,
      ST_QUIET = 3'b010,
      ST_GAP = 3'b011,
      ST_SHOCK2 = 3'b100,
      ST_HOLD = 3'b101
   } tap_state_e;

   typedef struct packed {
      logic [2:0] axisEn;
      logic latchEn;
      logic oneRoute;
      logic twoRoute;
      logic doubleMode;
      logic [4:0] threshold;
      logic [1:0] shock;
      logic [1:0] quiet;
      logic [3:0] gap;
   } tap_cfg_s;

   typedef struct packed {
      logic [2:0] over;
      logic [2:0] neg;
   } slope_flags_s;
endpackage

/* File: rtl/slope_axis.sv */
// Slope and threshold comparison for one axis
`timescale 1ns/10ps
module slope_axis #(
   parameter int DW = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sampleValid,
   input wire logic signed [DW-1:0] sample,
   input wire logic [4:0] threshold,
   output logic over,
   output logic neg
);
   logic signed [DW-1:0] prev_r, prev_nxt;
   logic signed [DW:0] diff;
   logic signed [DW:0] slope;
   logic [DW:0] mag;
   logic [DW:0] thsScaled;

   always_comb begin
      diff = DW'(0) + {sample[DW-1], sample} - {prev_r[DW-1], prev_r};
      slope = diff >>> 1;
      mag = slope[DW] ? (DW+1)'(-slope) : slope;
      // One step is full scale over 32
      thsScaled = (DW+1)'({threshold, {(DW-6){1'b0}}});
      over = sampleValid && (mag > thsScaled);
      neg = slope[DW];
      prev_nxt = sampleValid ? sample : prev_r;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prev_r <= '0;
      end else begin
         prev_r <= prev_nxt;
      end
   end
endmodule

/* File: rtl/tap_event_detector.sv */
// Single and double tap recognition with register port and pin one output
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module tap_event_detector #(
   parameter int DW = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic sampleValid,
   input wire logic signed [DW-1:0] accelX,
   input wire logic signed [DW-1:0] accelY,
   input wire logic signed [DW-1:0] accelZ,
   input wire logic inactive,
   output logic interrupt_pin_one
);
   logic [7:0] control_three_r, control_three_nxt;
   logic [7:0] pin1_routing_control_r, pin1_routing_control_nxt;
   logic [7:0] knock_slope_threshold_r, knock_slope_threshold_nxt;
   logic [7:0] tap_window_timing_r, tap_window_timing_nxt;
   logic [7:0] activity_threshold_config_r, activity_threshold_config_nxt;
   logic [7:0] tap_event_report_r, tap_event_report_nxt;
   logic [7:0] rdData_r, rdData_nxt;
   tap_pkg::tap_cfg_s cfg;
   tap_pkg::slope_flags_s flags;
   logic [2:0] overEn;
   logic anyOver;
   logic [2:0] axisSeen_r, axisSeen_nxt;
   logic signSeen_r, signSeen_nxt;
   tap_pkg::tap_state_e state_r, state_nxt;
   logic [tap_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [tap_pkg::CNT_W-1:0] pulseCnt_r, pulseCnt_nxt;
   logic pulseOne_r, pulseOne_nxt;
   logic pulseTwo_r, pulseTwo_nxt;
   logic latchOne_r, latchOne_nxt;
   logic latchTwo_r, latchTwo_nxt;
   logic [tap_pkg::CNT_W-1:0] shockLen, quietLen, gapLen;
   logic singleEvt, doubleEvt;
   logic reportRead;
   logic latchActive;
   logic pin_r, pin_nxt;

   function automatic logic [tap_pkg::CNT_W-1:0] winLen(input logic [3:0] field,
         input int zeroLen, input int step);
      logic [tap_pkg::CNT_W-1:0] r;
      if (field == 4'h0) begin
         r = tap_pkg::CNT_W'(zeroLen);
      end else begin
         r = tap_pkg::CNT_W'(int'(field) * step);
      end
      return r;
   endfunction

   // Report order puts X in the top axis bit
   function automatic logic [2:0] axisOrder(input logic [2:0] hits);
      return {hits[0], hits[1], hits[2]};
   endfunction

   // Negative on any triggering axis
   function automatic logic anyNeg(input logic [2:0] hits, input logic [2:0] negs);
      return |(hits & negs);
   endfunction

   always_comb begin
      cfg.axisEn = control_three_r[tap_pkg::AXIS_EN_LSB +: 3];
      cfg.latchEn = control_three_r[tap_pkg::LATCH_BIT];
      cfg.oneRoute = pin1_routing_control_r[tap_pkg::ONE_ROUTE_BIT];
      cfg.twoRoute = pin1_routing_control_r[tap_pkg::TWO_ROUTE_BIT];
      cfg.doubleMode = activity_threshold_config_r[tap_pkg::DOUBLE_MODE_BIT];
      cfg.threshold = knock_slope_threshold_r[4:0];
      cfg.shock = tap_window_timing_r[tap_pkg::SHOCK_LSB +: 2];
      cfg.quiet = tap_window_timing_r[tap_pkg::QUIET_LSB +: 2];
      cfg.gap = tap_window_timing_r[tap_pkg::GAP_LSB +: 4];
      shockLen = winLen({2'b00, cfg.shock}, tap_pkg::SHOCK_ZERO, tap_pkg::SHOCK_STEP);
      quietLen = winLen({2'b00, cfg.quiet}, tap_pkg::QUIET_ZERO, tap_pkg::QUIET_STEP);
      gapLen = winLen(cfg.gap, tap_pkg::GAP_ZERO, tap_pkg::GAP_STEP);
   end

   // Axis slope units
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gAxis
         logic signed [DW-1:0] smp;
         assign smp = (g == 0) ? accelX : ((g == 1) ? accelY : accelZ);
         slope_axis #(.DW(DW)) uAxis (
            .clk_sys(clk_sys),
            .reset(reset),
            .sampleValid(sampleValid),
            .sample(smp),
            .threshold(cfg.threshold),
            .over(flags.over[g]),
            .neg(flags.neg[g])
         );
      end
   endgenerate

   assign overEn = flags.over & cfg.axisEn;
   assign anyOver = |overEn;
   assign reportRead = regRead && (regAddr == tap_pkg::ADDR_REPORT);
   // Latch only counts when the routed event matches the mode
   assign latchActive = cfg.latchEn &&
      (cfg.doubleMode ? cfg.twoRoute : cfg.oneRoute);

   // Tap state machine, stepped per sample
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      axisSeen_nxt = axisSeen_r;
      signSeen_nxt = signSeen_r;
      singleEvt = 1'b0;
      doubleEvt = 1'b0;
      if (sampleValid) begin
         case (state_r)
            tap_pkg::ST_IDLE: begin
               if (anyOver && !inactive) begin
                  state_nxt = tap_pkg::ST_SHOCK1;
                  cnt_nxt = tap_pkg::CNT_W'(1);
                  axisSeen_nxt = axisOrder(overEn);
                  signSeen_nxt = anyNeg(overEn, flags.neg);
               end
            end
            tap_pkg::ST_SHOCK1: begin
               if (!anyOver) begin
                  singleEvt = 1'b1;
                  state_nxt = cfg.doubleMode ? tap_pkg::ST_QUIET : tap_pkg::ST_HOLD;
                  cnt_nxt = '0;
               end else if (cnt_r >= shockLen) begin
                  state_nxt = tap_pkg::ST_HOLD;
                  cnt_nxt = '0;
               end else begin
                  cnt_nxt = cnt_r + tap_pkg::CNT_W'(1);
               end
            end
            tap_pkg::ST_QUIET: begin
               if (anyOver) begin
                  state_nxt = tap_pkg::ST_HOLD;
               end else if (cnt_r + tap_pkg::CNT_W'(1) >= quietLen) begin
                  state_nxt = tap_pkg::ST_GAP;
                  cnt_nxt = '0;
               end else begin
                  cnt_nxt = cnt_r + tap_pkg::CNT_W'(1);
               end
            end
            tap_pkg::ST_GAP: begin
               if (anyOver) begin
                  state_nxt = tap_pkg::ST_SHOCK2;
                  cnt_nxt = tap_pkg::CNT_W'(1);
                  axisSeen_nxt = axisOrder(overEn);
                  signSeen_nxt = anyNeg(overEn, flags.neg);
               end else if (cnt_r + tap_pkg::CNT_W'(1) >= gapLen) begin
                  state_nxt = tap_pkg::ST_IDLE;
               end else begin
                  cnt_nxt = cnt_r + tap_pkg::CNT_W'(1);
               end
            end
            tap_pkg::ST_SHOCK2: begin
               if (!anyOver) begin
                  doubleEvt = 1'b1;
                  state_nxt = tap_pkg::ST_IDLE;
               end else if (cnt_r >= shockLen) begin
                  state_nxt = tap_pkg::ST_HOLD;
               end else begin
                  cnt_nxt = cnt_r + tap_pkg::CNT_W'(1);
               end
            end
            tap_pkg::ST_HOLD: begin
               // Wait for the slope to settle before rearming
               if (!anyOver) begin
                  state_nxt = tap_pkg::ST_IDLE;
               end
            end
            default: state_nxt = tap_pkg::ST_IDLE;
         endcase
         if (inactive) begin
            state_nxt = tap_pkg::ST_IDLE;
            singleEvt = 1'b0;
            doubleEvt = 1'b0;
         end
      end
   end

   // Interrupt pulses and latches
   always_comb begin
      pulseOne_nxt = pulseOne_r;
      pulseTwo_nxt = pulseTwo_r;
      pulseCnt_nxt = pulseCnt_r;
      latchOne_nxt = latchOne_r && !reportRead;
      latchTwo_nxt = latchTwo_r && !reportRead;
      if (sampleValid && (pulseOne_r || pulseTwo_r)) begin
         if (pulseCnt_r + tap_pkg::CNT_W'(1) >= quietLen) begin
            pulseOne_nxt = 1'b0;
            pulseTwo_nxt = 1'b0;
            pulseCnt_nxt = '0;
         end else begin
            pulseCnt_nxt = pulseCnt_r + tap_pkg::CNT_W'(1);
         end
      end
      if (singleEvt) begin
         if (latchActive && !cfg.doubleMode) begin
            latchOne_nxt = 1'b1;
         end else begin
            pulseOne_nxt = 1'b1;
            pulseCnt_nxt = '0;
         end
      end
      if (doubleEvt) begin
         if (latchActive && cfg.doubleMode) begin
            latchTwo_nxt = 1'b1;
         end else begin
            pulseTwo_nxt = 1'b1;
            pulseCnt_nxt = '0;
         end
      end
      if (inactive) begin
         pulseOne_nxt = 1'b0;
         pulseTwo_nxt = 1'b0;
      end
      pin_nxt = (cfg.oneRoute && (pulseOne_nxt || latchOne_nxt)) ||
         (cfg.twoRoute && (pulseTwo_nxt || latchTwo_nxt));
      if (inactive) begin
         pin_nxt = 1'b0;
      end
   end

   // Report register: new event wins over the read clear
   always_comb begin
      tap_event_report_nxt = tap_event_report_r;
      if (reportRead) begin
         tap_event_report_nxt = tap_pkg::RESET_VAL;
      end
      if (singleEvt || doubleEvt) begin
         tap_event_report_nxt = {1'b0, 1'b1, singleEvt, doubleEvt, signSeen_r,
            axisSeen_r};
      end
   end

   // Register port
   always_comb begin
      control_three_nxt = control_three_r;
      pin1_routing_control_nxt = pin1_routing_control_r;
      knock_slope_threshold_nxt = knock_slope_threshold_r;
      tap_window_timing_nxt = tap_window_timing_r;
      activity_threshold_config_nxt = activity_threshold_config_r;
      rdData_nxt = 8'h00;
      if (regWrite) begin
         if (regAddr == tap_pkg::ADDR_CTRL_THREE) begin
            control_three_nxt = regWrData;
         end else if (regAddr == tap_pkg::ADDR_ROUTING) begin
            pin1_routing_control_nxt = regWrData;
         end else if (regAddr == tap_pkg::ADDR_KNOCK_THS) begin
            knock_slope_threshold_nxt = regWrData;
         end else if (regAddr == tap_pkg::ADDR_TIMING) begin
            tap_window_timing_nxt = regWrData;
         end else if (regAddr == tap_pkg::ADDR_ACT_CFG) begin
            activity_threshold_config_nxt = regWrData;
         end
      end
      if (regRead) begin
         if (regAddr == tap_pkg::ADDR_CTRL_THREE) begin
            rdData_nxt = control_three_r;
         end else if (regAddr == tap_pkg::ADDR_ROUTING) begin
            rdData_nxt = pin1_routing_control_r;
         end else if (regAddr == tap_pkg::ADDR_KNOCK_THS) begin
            rdData_nxt = knock_slope_threshold_r;
         end else if (regAddr == tap_pkg::ADDR_TIMING) begin
            rdData_nxt = tap_window_timing_r;
         end else if (regAddr == tap_pkg::ADDR_ACT_CFG) begin
            rdData_nxt = activity_threshold_config_r;
         end else if (regAddr == tap_pkg::ADDR_REPORT) begin
            rdData_nxt = tap_event_report_r;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         control_three_r <= tap_pkg::RESET_VAL;
         pin1_routing_control_r <= tap_pkg::RESET_VAL;
         knock_slope_threshold_r <= tap_pkg::RESET_VAL;
         tap_window_timing_r <= tap_pkg::RESET_VAL;
         activity_threshold_config_r <= tap_pkg::RESET_VAL;
         tap_event_report_r <= tap_pkg::RESET_VAL;
         rdData_r <= 8'h00;
         state_r <= tap_pkg::ST_IDLE;
         cnt_r <= '0;
         axisSeen_r <= 3'h0;
         signSeen_r <= 1'b0;
         pulseCnt_r <= '0;
         pulseOne_r <= 1'b0;
         pulseTwo_r <= 1'b0;
         latchOne_r <= 1'b0;
         latchTwo_r <= 1'b0;
         pin_r <= 1'b0;
      end else begin
         control_three_r <= control_three_nxt;
         pin1_routing_control_r <= pin1_routing_control_nxt;
         knock_slope_threshold_r <= knock_slope_threshold_nxt;
         tap_window_timing_r <= tap_window_timing_nxt;
         activity_threshold_config_r <= activity_threshold_config_nxt;
         tap_event_report_r <= tap_event_report_nxt;
         rdData_r <= rdData_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         axisSeen_r <= axisSeen_nxt;
         signSeen_r <= signSeen_nxt;
         pulseCnt_r <= pulseCnt_nxt;
         pulseOne_r <= pulseOne_nxt;
         pulseTwo_r <= pulseTwo_nxt;
         latchOne_r <= latchOne_nxt;
         latchTwo_r <= latchTwo_nxt;
         pin_r <= pin_nxt;
      end
   end

   assign regRdData = rdData_r;
   assign interrupt_pin_one = pin_r;
endmodule

/* File: verif/tap_event_detector_properties.sv */
// Port checker for the tap detector, bound to the top module
`timescale 1ns/10ps
module tap_event_detector_properties (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic sampleValid,
   input wire logic inactive,
   input wire logic interrupt_pin_one
);
   logic latch_r, latch_nxt, dbl_r, dbl_nxt;
   logic [1:0] quiet_r, quiet_nxt;
   logic [3:0] pulseCnt_r, pulseCnt_nxt, quietLen;
   logic rdRep;
   assign rdRep = regRead && regAddr == tap_pkg::ADDR_REPORT;
   assign quietLen = (quiet_r == 2'b00) ? 4'h2 : {quiet_r, 2'b00};
   // Shadow of config and pulse length counter
   always_comb begin
      latch_nxt = latch_r;
      dbl_nxt = dbl_r;
      quiet_nxt = quiet_r;
      pulseCnt_nxt = interrupt_pin_one ? pulseCnt_r + {3'b000, sampleValid} : 4'h0;
      if (regWrite && regAddr == tap_pkg::ADDR_CTRL_THREE) begin
         latch_nxt = regWrData[tap_pkg::LATCH_BIT];
      end
      if (regWrite && regAddr == tap_pkg::ADDR_ACT_CFG) begin
         dbl_nxt = regWrData[tap_pkg::DOUBLE_MODE_BIT];
      end
      if (regWrite && regAddr == tap_pkg::ADDR_TIMING) begin
         quiet_nxt = regWrData[tap_pkg::QUIET_LSB +: 2];
      end
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         latch_r <= 1'b0;
         dbl_r <= 1'b0;
         quiet_r <= 2'b00;
         pulseCnt_r <= 4'h0;
      end else begin
         latch_r <= latch_nxt;
         dbl_r <= dbl_nxt;
         quiet_r <= quiet_nxt;
         pulseCnt_r <= pulseCnt_nxt;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_top_bit_zero: assert property ($past(rdRep) |-> regRdData[7] == 1'b0)
      else $error("read data top bit set");
   a_any_flag: assert property ($past(rdRep) |-> regRdData[6] == (regRdData[5] | regRdData[4]))
      else $error("any flag differs from single or double");
   a_mode0_single: assert property (!dbl_r && $past(rdRep) |-> !regRdData[4])
      else $error("double reported in single mode");
   a_inact_mute: assert property ($past(inactive) |-> !interrupt_pin_one)
      else $error("pin high while inactive");
   a_rise_cause: assert property ($rose(interrupt_pin_one) |->
      $past(sampleValid) || $past(sampleValid, 2) || $past(inactive, 2))
      else $error("pin rose without a sample");
   a_pulse_len: assert property ($fell(interrupt_pin_one) && !latch_r && !$past(inactive)
      && !$past(regWrite) |-> pulseCnt_r == quietLen)
      else $error("pulse length differs from quiet window");
   a_latch_hold: assert property (latch_r && !dbl_r && interrupt_pin_one && !regRead
      && !regWrite && !inactive |=> interrupt_pin_one)
      else $error("latched pin dropped without read");
   a_read_clear: assert property (latch_r && !dbl_r && interrupt_pin_one && rdRep
      && !sampleValid && !$past(sampleValid) |-> ##[1:2] !interrupt_pin_one)
      else $error("latched pin not cleared by read");
   a_clear_twice: assert property (rdRep && !sampleValid && !$past(sampleValid) ##1
      rdRep && !sampleValid |=> regRdData == 8'h00)
      else $error("report not cleared by read");
   c_pin_rise: cover property ($rose(interrupt_pin_one));
   c_double: cover property ($past(rdRep) && regRdData[4]);
   c_latched_read: cover property (latch_r && interrupt_pin_one && rdRep);
endmodule
bind tap_event_detector tap_event_detector_properties u_props (.clk_sys(clk_sys),
   .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .sampleValid(sampleValid),
   .inactive(inactive), .interrupt_pin_one(interrupt_pin_one));

/* File: verif/tap_event_detector_test.sv */
// Self-checking bench for the tap detector
`timescale 1ns/10ps
module tap_event_detector_test;
   localparam logic [7:0] C3 = tap_pkg::ADDR_CTRL_THREE;
   localparam logic [7:0] RT = tap_pkg::ADDR_ROUTING;
   localparam logic [7:0] TM = tap_pkg::ADDR_TIMING;
   localparam logic [7:0] MD = tap_pkg::ADDR_ACT_CFG;
   localparam logic [7:0] RP = tap_pkg::ADDR_REPORT;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic regWrite = 1'b0, regRead = 1'b0, sampleValid = 1'b0, inactive = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rdv;
   logic signed [15:0] accelX = 16'sh0000, accelY = 16'sh0000, accelZ = 16'sh0000;
   logic signed [15:0] v [2:0] = '{default: 16'sh0000};
   logic [7:0] adrs [7] = '{C3, RT, tap_pkg::ADDR_KNOCK_THS, TM, MD, RP, 8'h40};
   logic [2:0] en = 3'b111;
   logic interrupt_pin_one;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   always #20 clk_sys = ~clk_sys;
   tap_event_detector #(.DW(16)) i_dut (.clk_sys(clk_sys), .reset(reset),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .sampleValid(sampleValid), .accelX(accelX), .accelY(accelY),
      .accelZ(accelZ), .inactive(inactive), .interrupt_pin_one(interrupt_pin_one));
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 10000) begin
         n_mismatch++;
         $display("MISMATCH %0t timeout", $time);
         results();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bit1(input logic got, input logic exp);
      #1;
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input int n);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      repeat (n) @(posedge clk_sys);
      regRead <= 1'b0;
      #1 rdv = regRdData;
   endtask
   // Fixed sample spacing stands for a valid tap rate
   task automatic smp;
      @(posedge clk_sys);
      sampleValid <= 1'b1;
      accelX <= v[2];
      accelY <= v[1];
      accelZ <= v[0];
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic idle(input int n);
      repeat (n) smp();
   endtask
   // Step then hold on axes in m; e gets the expected report
   task automatic hit(input logic [2:0] m, output logic [7:0] e);
      logic ng;
      ng = 1'b0;
      for (int k = 0; k < 3; k++) begin
         if (m[k]) begin
            ng |= en[k] && ((v[k] ^ 16'sh1000) < v[k]);
            v[k] = v[k] ^ 16'sh1000;
         end
      end
      smp();
      smp();
      e = ((m & en) != 3'b000) ? {4'h6, ng, m & en} : 8'h00;
   endtask
   task automatic knock(input logic [2:0] m, output logic [7:0] e);
      hit(m, e);
      idle(2);
   endtask
   initial begin
      logic [7:0] e;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      wr(RP, 8'hff);
      foreach (adrs[i]) begin
         rd(adrs[i], 1);
         chk(rdv, 8'h00);
      end
      wr(tap_pkg::ADDR_KNOCK_THS, 8'h01);
      wr(C3, 8'h38);
      wr(RT, 8'h40);
      rd(C3, 1);
      chk(rdv, 8'h38);
      v[2] = 16'sh0800;
      idle(2);
      rd(RP, 1);
      chk(rdv, 8'h00);
      v[2] = 16'sh1002;
      smp();
      bit1(interrupt_pin_one, 1'b0);
      smp();
      bit1(interrupt_pin_one, 1'b1);
      smp();
      bit1(interrupt_pin_one, 1'b1);
      smp();
      bit1(interrupt_pin_one, 1'b0);
      rd(RP, 1);
      chk(rdv, 8'h64);
      knock(3'b100, e);
      rd(RP, 1);
      chk(rdv, e);
      rd(RP, 2);
      chk(rdv, 8'h00);
      $display("test slope and single tap done");
      for (int i = 0; i < 3; i++) begin
         en = 3'b001 << i;
         wr(C3, {2'b00, en[0], en[1], en[2], 3'b000});
         knock(~en, e);
         rd(RP, 1);
         chk(rdv, e);
         knock(3'b111, e);
         rd(RP, 1);
         chk(rdv, e);
      end
      en = 3'b111;
      $display("test axis enables done");
      wr(C3, 8'h3c);
      knock(3'b010, e);
      idle(2);
      bit1(interrupt_pin_one, 1'b1);
      rd(RP, 1);
      chk(rdv, e);
      idle(1);
      bit1(interrupt_pin_one, 1'b0);
      wr(RT, 8'h00);
      hit(3'b001, e);
      bit1(interrupt_pin_one, 1'b0);
      idle(2);
      rd(RP, 1);
      chk(rdv, e);
      wr(C3, 8'h38);
      wr(RT, 8'h40);
      inactive <= 1'b1;
      hit(3'b100, e);
      bit1(interrupt_pin_one, 1'b0);
      idle(2);
      inactive <= 1'b0;
      rd(RP, 1);
      chk(rdv, 8'h00);
      $display("test latch and inactivity done");
      v = '{default: 16'sh0000};
      idle(4);
      rd(RP, 1);
      for (int f = 0; f < 2; f++) begin
         wr(TM, {4'h0, f[1:0], f[1:0]});
         for (int n = 0; n < 2; n++) begin
            repeat ((f == 1 ? 8 : 4) + n) begin
               v[2] = v[2] + 16'sh0900;
               smp();
            end
            smp();
            rd(RP, 1);
            chk(rdv, n == 1 ? 8'h00 : 8'h64);
            while (v[2] != 16'sh0000) begin
               v[2] = v[2] > 16'sh0400 ? v[2] - 16'sh0400 : 16'sh0000;
               smp();
            end
            rd(RP, 1);
         end
      end
      wr(TM, 8'h00);
      $display("test shock and quiet windows done");
      wr(MD, 8'h80);
      wr(RT, 8'h08);
      for (int n = 15; n < 17; n++) begin
         knock(3'b100, e);
         bit1(interrupt_pin_one, 1'b0);
         idle(n);
         hit(3'b100, e);
         idle(20);
         rd(RP, 1);
         bit1(rdv[4], n == 15);
      end
      hit(3'b001, e);
      hit(3'b001, e);
      knock(3'b001, e);
      idle(20);
      rd(RP, 1);
      bit1(rdv[4], 1'b0);
      wr(C3, 8'h3c);
      wr(RT, 8'h48);
      knock(3'b100, e);
      bit1(interrupt_pin_one, 1'b0);
      knock(3'b100, e);
      idle(2);
      bit1(interrupt_pin_one, 1'b1);
      rd(RP, 1);
      bit1(rdv[4], 1'b1);
      idle(1);
      bit1(interrupt_pin_one, 1'b0);
      wr(MD, 8'h00);
      wr(C3, 8'h38);
      knock(3'b100, e);
      knock(3'b100, e);
      idle(4);
      rd(RP, 1);
      bit1(rdv[4], 1'b0);
      $display("test double tap done");
      results();
   end
endmodule
